/* cec_defines.svh */
// Offsets, field positions and reset values of the comparator event block
// Behaviour
// - Debug pin enable resets to one; software clears it to free the pin.
// - With capture routing set, comparator output feeds timer capture channel zero.
// - With capture routing set, timer channel zero pin is disconnected externally.
// - Clock gate bit resets to one; clearing it stops the module clock.
// - In wait mode the comparator runs and its interrupt wakes the processor.
// - In stop3 an enabled comparator keeps evaluating compare events.
// - In stop3 the result still drives the output pin when enabled.
// - In stop3 an enabled compare event sets the flag and, with the interrupt enabled, exits stop.
// - Leaving stop through reset returns all state to reset values.
// - Stop2 powers the comparator down; afterwards its state is at reset.
// - In active background debug the comparator keeps operating normally.
// - With the debug pin function enabled, the result never reaches the pin.
// - Interrupt source selects rising, falling or both comparator edges.
// - Edge mode 00 falling, 01 rising, 10 falling, 11 both edges.
// - Event flag stays set until software writes one; zero leaves it.
// - Interrupt request is high exactly while interrupt enable, flag and the clock gate bit are all set and stop2 is off.
// - Result bit reads the live comparator result, zero while disabled.
`ifndef CEC_DEFINES_SVH
`define CEC_DEFINES_SVH

// ==========================================================
// Register map
`define CEC_ADDR_W 4
`define CEC_OFF_CTRL 4'h0
`define CEC_OFF_SYS 4'h4

// ==========================================================
// Control and status register fields
`define CEC_BIT_EN 7
`define CEC_BIT_BGS 6
`define CEC_BIT_FLAG 5
`define CEC_BIT_IE 4
`define CEC_BIT_RES 3
`define CEC_BIT_OPE 2
`define CEC_MODE_HI 1
`define CEC_MODE_LO 0
`define CEC_CTRL_RST 8'h00

// ==========================================================
// System options fields
`define CEC_BIT_DBGPE 0
`define CEC_BIT_ROUTE 1
`define CEC_BIT_GATE 2
`define CEC_DBGPE_RST 1'b1
`define CEC_ROUTE_RST 1'b0
`define CEC_GATE_RST 1'b1

// ==========================================================
// Edge modes and bus answers
`define CEC_MODE_FALL0 2'h0
`define CEC_MODE_RISE 2'h1
`define CEC_MODE_FALL1 2'h2
`define CEC_MODE_BOTH 2'h3
`define CEC_RESP_OKAY 2'h0
`define CEC_RESP_SLVERR 2'h2

`endif

/* cec_pkg.sv */
// Types shared by the comparator event block
package cec_pkg;
  typedef logic [1:0] cec_edge_t;
  typedef logic [1:0] cec_resp_t;
endpackage : cec_pkg

/* cec_sync.sv */
// Two-stage synchroniser for an asynchronous level
module cec_sync #(
  parameter int STAGES = 2
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic d_async, // Asynchronous level
  output logic q_sync // Synchronised level
);
  logic [STAGES-1:0] chain_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], d_async};
    end
  end

  assign q_sync = chain_q[STAGES-1];
endmodule : cec_sync

/* cec_top.sv */
// Comparator event control with AXI4-Lite register slave
`include "cec_defines.svh"
module cec_top (
  input wire logic aclk, // Bus clock
  input wire logic aresetn, // Synchronous reset, active low
  // AXI4-Lite slave
  input wire logic [`CEC_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [`CEC_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  // Analog side and chip modes
  input wire logic cmp_raw, // Raw comparator output, asynchronous
  input wire logic wait_mode, // Chip in wait mode
  input wire logic stop3_mode, // Chip in stop3 mode
  input wire logic stop2_mode, // Chip in stop2, module powered down
  input wire logic debug_halt, // CPU halted in background debug
  output logic analog_enable, // Powers the analog comparator
  output logic bandgap_select, // Bandgap as non-inverting input
  output logic module_clock_en, // Bus clock gate to the comparator
  // Pins and timer
  output logic comparator_output_pin_o, // Result onto the shared pin
  output logic comparator_output_pin_oe, // Drive enable of the shared pin
  output logic debug_pin_function, // Shared pin owned by debug
  input wire logic timer_ch0_pin_i, // Timer channel zero pin level
  input wire logic timer_ch0_out_i, // Timer channel zero drive value
  input wire logic timer_ch0_oe_i, // Timer channel zero drive enable
  output logic timer_ch0_pin_o, // Channel zero pin drive value
  output logic timer_ch0_pin_oe, // Channel zero pin drive enable
  output logic timer_capture_in, // Capture input of channel zero
  // Events
  output logic irq, // Interrupt request
  output logic wakeup // Wake request out of wait or stop
);
  // ==========================================================
  // Control state
  logic en_q;
  logic bgs_q;
  logic flag_q;
  logic ie_q;
  logic ope_q;
  cec_pkg::cec_edge_t mode_q;
  logic dbg_pe_q;
  logic route_q;
  logic gate_q;
  logic mod_rst;
  logic running;

  // Stop2 powers the module down, so its own state is held in reset
  assign mod_rst = !aresetn || stop2_mode;
  // Wait, stop3 and debug halt do not stop the comparator
  assign running = gate_q && !stop2_mode;

  // ==========================================================
  // Comparator result synchronisation and edge detection
  logic res_sync;
  logic res_prev_q;
  logic res_live;
  logic rise;
  logic fall;
  logic event_hit;

  cec_sync #(
    .STAGES(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_async(cmp_raw),
    .q_sync(res_sync)
  );

  // Previous value is tracked even while disabled, so enabling the
  // module never reports a stale edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_prev_q <= 1'b0;
    end else begin
      res_prev_q <= res_sync;
    end
  end

  assign res_live = res_sync && en_q && running;
  assign rise = res_sync && !res_prev_q;
  assign fall = !res_sync && res_prev_q;

  always_comb begin
    case (mode_q)
      `CEC_MODE_FALL0: event_hit = fall;
      `CEC_MODE_RISE: event_hit = rise;
      `CEC_MODE_FALL1: event_hit = fall;
      `CEC_MODE_BOTH: event_hit = rise || fall;
      default: event_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic aw_have_q;
  logic w_have_q;
  logic [`CEC_ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane0_q;
  logic bvalid_q;
  cec_pkg::cec_resp_t bresp_q;
  logic do_write;
  logic wr_ctrl;
  logic wr_sys;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl = do_write && w_lane0_q && running &&
                   (aw_addr_q == `CEC_OFF_CTRL);
  assign wr_sys = do_write && w_lane0_q && (aw_addr_q == `CEC_OFF_SYS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_byte_q <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CEC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      if (aw_addr_q == `CEC_OFF_CTRL || aw_addr_q == `CEC_OFF_SYS) begin
        bresp_q <= `CEC_RESP_OKAY;
      end else begin
        bresp_q <= `CEC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================
  // Control and status register
  always_ff @(posedge aclk) begin
    if (mod_rst) begin
      en_q <= 1'b0;
      bgs_q <= 1'b0;
      ie_q <= 1'b0;
      ope_q <= 1'b0;
      mode_q <= `CEC_MODE_FALL0;
    end else if (wr_ctrl) begin
      en_q <= w_byte_q[`CEC_BIT_EN];
      // Bandgap use in low-power modes is policed by software
      bgs_q <= w_byte_q[`CEC_BIT_BGS];
      ie_q <= w_byte_q[`CEC_BIT_IE];
      ope_q <= w_byte_q[`CEC_BIT_OPE];
      mode_q <= w_byte_q[`CEC_MODE_HI:`CEC_MODE_LO];
    end
  end

  // An edge in the clearing cycle wins over the write of one
  always_ff @(posedge aclk) begin
    if (mod_rst) begin
      flag_q <= 1'b0;
    end else if (en_q && running && event_hit) begin
      flag_q <= 1'b1;
    end else if (wr_ctrl && w_byte_q[`CEC_BIT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // System options: pin ownership, capture routing, clock gate
  // Not inside the comparator, so stop2 does not clear it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_pe_q <= `CEC_DBGPE_RST;
      route_q <= `CEC_ROUTE_RST;
      gate_q <= `CEC_GATE_RST;
    end else if (wr_sys) begin
      dbg_pe_q <= w_byte_q[`CEC_BIT_DBGPE];
      route_q <= w_byte_q[`CEC_BIT_ROUTE];
      gate_q <= w_byte_q[`CEC_BIT_GATE];
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic rvalid_q;
  logic [7:0] rdata_q;
  cec_pkg::cec_resp_t rresp_q;
  logic [7:0] ctrl_view;
  logic [7:0] sys_view;

  // A gated module has no clock, so its register reads as zero
  always_comb begin
    ctrl_view = 8'h00;
    if (running) begin
      ctrl_view[`CEC_BIT_EN] = en_q;
      ctrl_view[`CEC_BIT_BGS] = bgs_q;
      ctrl_view[`CEC_BIT_FLAG] = flag_q;
      ctrl_view[`CEC_BIT_IE] = ie_q;
      ctrl_view[`CEC_BIT_RES] = res_live;
      ctrl_view[`CEC_BIT_OPE] = ope_q;
      ctrl_view[`CEC_MODE_HI:`CEC_MODE_LO] = mode_q;
    end
  end

  always_comb begin
    sys_view = 8'h00;
    sys_view[`CEC_BIT_DBGPE] = dbg_pe_q;
    sys_view[`CEC_BIT_ROUTE] = route_q;
    sys_view[`CEC_BIT_GATE] = gate_q;
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= `CEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      case (s_axi_araddr)
        `CEC_OFF_CTRL: begin
          rdata_q <= ctrl_view;
          rresp_q <= `CEC_RESP_OKAY;
        end
        `CEC_OFF_SYS: begin
          rdata_q <= sys_view;
          rresp_q <= `CEC_RESP_OKAY;
        end
        default: begin
          rdata_q <= 8'h00;
          rresp_q <= `CEC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h000000, rdata_q};

  // ==========================================================
  // Pins, timer routing, events
  logic pin_drive;

  assign analog_enable = en_q && running;
  assign bandgap_select = bgs_q && running;
  assign module_clock_en = gate_q;
  assign debug_pin_function = dbg_pe_q;

  // Pin drive ignores stop3, so the result stays visible there
  assign pin_drive = ope_q && en_q && running && !dbg_pe_q;
  assign comparator_output_pin_o = res_live && pin_drive;
  assign comparator_output_pin_oe = pin_drive;

  // Routing cuts the pin off whatever the timer asks for
  assign timer_capture_in = route_q ? res_live : timer_ch0_pin_i;
  assign timer_ch0_pin_oe = timer_ch0_oe_i && !route_q;
  assign timer_ch0_pin_o = timer_ch0_out_i && !route_q;

  assign irq = ie_q && flag_q && running;
  // Any pending request wakes the chip out of wait or stop3
  assign wakeup = irq && (wait_mode || stop3_mode);

endmodule : cec_top

/* cec_analog_model.sv */
// Behavioural model of the analog comparator feeding the block
module cec_analog_model (
  input wire logic analog_enable, // Comparator powered
  input wire logic bandgap_select, // Bandgap used as reference
  input wire logic bg_buf_en, // Bandgap buffer switched on
  input wire logic plus_in, // Plus input above minus input
  input wire logic bandgap_in, // Bandgap above minus input
  output logic cmp_raw // Comparator output
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Comparator
  // Unpowered output means nothing, so it shows the opposite level
  always_comb begin
    if (!analog_enable)
      cmp_raw = !plus_in;
    else if (bandgap_select)
      cmp_raw = bandgap_in && bg_buf_en;
    else
      cmp_raw = plus_in;
  end
endmodule : cec_analog_model

/* cec_top_properties.sv */
// Port-level checks of the comparator event block
module cec_top_properties (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic cmp_raw, // Raw comparator level
  input wire logic wait_mode, // Wait mode
  input wire logic stop3_mode, // Stop3 mode
  input wire logic stop2_mode, // Stop2 mode
  input wire logic analog_enable, // Analog power
  input wire logic module_clock_en, // Clock gate
  input wire logic comparator_output_pin_o, // Pin value
  input wire logic comparator_output_pin_oe, // Pin enable
  input wire logic debug_pin_function, // Pin owned by debug
  input wire logic timer_ch0_pin_i, // Timer pin level
  input wire logic timer_ch0_oe_i, // Timer drive enable
  input wire logic timer_ch0_pin_oe, // Timer pin enable
  input wire logic timer_capture_in, // Capture input
  input wire logic irq, // Interrupt
  input wire logic wakeup // Wake request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Checks
  chk_reset_state: assert property (
    disable iff (1'b0) !aresetn |=> debug_pin_function && module_clock_en
    && !irq) else $error("state after reset wrong");
  chk_wake_request: assert property (
    wakeup == (irq && (wait_mode || stop3_mode)))
    else $error("wake request wrong");
  chk_route_pin: assert property (
    timer_ch0_pin_oe |-> timer_ch0_oe_i) else $error("timer pin drive");
  chk_capture_pin: assert property (
    timer_ch0_pin_oe |-> timer_capture_in == timer_ch0_pin_i)
    else $error("capture source wrong");
  chk_pin_debug: assert property (
    comparator_output_pin_oe |-> !debug_pin_function)
    else $error("pin driven under debug");
  chk_pin_power: assert property (
    comparator_output_pin_oe |-> analog_enable && module_clock_en)
    else $error("pin driven while off");
  chk_stop2_off: assert property (
    stop2_mode |-> !analog_enable && !irq && !comparator_output_pin_oe)
    else $error("active in stop2");
  chk_irq_hold: assert property (
    irq && !stop2_mode |=> irq || stop2_mode || $rose(s_axi_bvalid))
    else $error("interrupt dropped");
  chk_pin_result: assert property (
    (cmp_raw && comparator_output_pin_oe) [*3] |-> comparator_output_pin_o)
    else $error("pin result late");
endmodule : cec_top_properties

/* comparator_event_control_test.sv */
// Self-checking bench of the comparator event block
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module comparator_event_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmp_raw, analog_enable, bandgap_select;
  logic module_clock_en, comparator_output_pin_o, comparator_output_pin_oe;
  logic debug_pin_function, timer_ch0_pin_o, timer_ch0_pin_oe;
  logic timer_capture_in, irq, wakeup;
  logic wait_mode = 0, stop3_mode = 0, stop2_mode = 0, debug_halt = 0;
  logic timer_ch0_pin_i = 0, timer_ch0_out_i = 0, timer_ch0_oe_i = 0;
  logic plus_in = 0, bandgap_in = 0, bg_buf_en = 0;
  logic [7:0] d;
  int n_errors = 0, tests_run = 0;
  cec_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cmp_raw(cmp_raw), .wait_mode(wait_mode),
    .stop3_mode(stop3_mode), .stop2_mode(stop2_mode),
    .debug_halt(debug_halt), .analog_enable(analog_enable),
    .bandgap_select(bandgap_select), .module_clock_en(module_clock_en),
    .comparator_output_pin_o(comparator_output_pin_o),
    .comparator_output_pin_oe(comparator_output_pin_oe),
    .debug_pin_function(debug_pin_function),
    .timer_ch0_pin_i(timer_ch0_pin_i), .timer_ch0_out_i(timer_ch0_out_i),
    .timer_ch0_oe_i(timer_ch0_oe_i), .timer_ch0_pin_o(timer_ch0_pin_o),
    .timer_ch0_pin_oe(timer_ch0_pin_oe),
    .timer_capture_in(timer_capture_in), .irq(irq), .wakeup(wakeup));
  cec_analog_model model_u (.analog_enable(analog_enable),
    .bandgap_select(bandgap_select), .bg_buf_en(bg_buf_en),
    .plus_in(plus_in), .bandgap_in(bandgap_in), .cmp_raw(cmp_raw));
  initial begin
    forever #5 aclk = ~aclk;
  end
  // ==========================================================
  // Bus and run control
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask : rd
  task automatic end_sim;
    $display("Checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(4'h0);
    `CHK("ctrl", 8'h00, d)
    rd(4'h4);
    `CHK("sys", 8'h05, d)
    `CHK("debug fn", 1'b1, debug_pin_function)
    rd(4'h8);
    `CHK("unmapped", 2'h2, r)
    wr(4'h8, 8'h00);
    `CHK("wr unmapped", 2'h2, r)
  endtask : t_reset
  task automatic t_modes;
    debug_halt <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 8'h80 | m[1:0]);
      cyc(4);
      wr(4'h0, 8'hA0 | m[1:0]);
      plus_in <= 1'b1;
      cyc(4);
      rd(4'h0);
      `CHK("rise flag", m[0], d[5])
      wr(4'h0, 8'hA0 | m[1:0]);
      plus_in <= 1'b0;
      cyc(4);
      rd(4'h0);
      `CHK("fall flag", m != 1, d[5])
    end
    debug_halt <= 1'b0;
  endtask : t_modes
  task automatic t_irq;
    wr(4'h0, 8'hB1);
    plus_in <= 1'b1;
    cyc(4);
    `CHK("irq set", 1'b1, irq)
    wr(4'h0, 8'h91);
    cyc(1);
    `CHK("flag kept", 1'b1, irq)
    @(posedge aclk);
    wait_mode <= 1'b1;
    cyc(1);
    `CHK("wait wake", 1'b1, wakeup)
    @(posedge aclk);
    wait_mode <= 1'b0;
    stop3_mode <= 1'b1;
    wr(4'h0, 8'hB1);
    cyc(1);
    `CHK("irq clear", 1'b0, irq)
    `CHK("stop3 idle", 1'b0, wakeup)
    @(posedge aclk);
    plus_in <= 1'b0;
    cyc(4);
    @(posedge aclk);
    plus_in <= 1'b1;
    cyc(4);
    `CHK("stop3 wake", 1'b1, wakeup)
    @(posedge aclk);
    stop3_mode <= 1'b0;
    wr(4'h0, 8'h81);
    cyc(1);
    `CHK("irq off", 1'b0, irq)
  endtask : t_irq
  task automatic t_pin;
    wr(4'h0, 8'h84);
    cyc(4);
    `CHK("debug pin", 1'b0, comparator_output_pin_oe)
    wr(4'h4, 8'h04);
    `CHK("wr okay", 2'h0, r)
    `CHK("debug off", 1'b0, debug_pin_function)
    stop3_mode <= 1'b1;
    cyc(1);
    `CHK("pin oe", 1'b1, comparator_output_pin_oe)
    `CHK("pin hi", 1'b1, comparator_output_pin_o)
    @(posedge aclk);
    plus_in <= 1'b0;
    cyc(4);
    `CHK("pin lo", 1'b0, comparator_output_pin_o)
    @(posedge aclk);
    stop3_mode <= 1'b0;
    // Bench selects the bandgap only in run mode, never in wait or stop modes
    bg_buf_en <= 1'b1;
    bandgap_in <= 1'b1;
    // Flag is still set from the stop3 edges, so clear it here
    wr(4'h0, 8'hE0);
    cyc(4);
    `CHK("bandgap sel", 1'b1, bandgap_select)
    rd(4'h0);
    `CHK("result", 8'hC8, d)
    wr(4'h0, 8'h00);
    cyc(4);
    rd(4'h0);
    `CHK("result off", 8'h00, d)
  endtask : t_pin
  task automatic t_route;
    timer_ch0_oe_i <= 1'b1;
    timer_ch0_out_i <= 1'b1;
    plus_in <= 1'b1;
    wr(4'h0, 8'h80);
    cyc(4);
    `CHK("timer oe", 1'b1, timer_ch0_pin_oe)
    `CHK("timer out", 1'b1, timer_ch0_pin_o)
    `CHK("capture pin", 1'b0, timer_capture_in)
    wr(4'h4, 8'h06);
    cyc(1);
    `CHK("timer off", 1'b0, timer_ch0_pin_oe)
    `CHK("timer out off", 1'b0, timer_ch0_pin_o)
    `CHK("capture cmp", 1'b1, timer_capture_in)
  endtask : t_route
  task automatic t_power;
    wr(4'h0, 8'hB1);
    plus_in <= 1'b0;
    cyc(4);
    @(posedge aclk);
    plus_in <= 1'b1;
    cyc(4);
    `CHK("stop2 irq", 1'b1, irq)
    @(posedge aclk);
    stop2_mode <= 1'b1;
    cyc(2);
    `CHK("stop2 power", 1'b0, analog_enable)
    @(posedge aclk);
    stop2_mode <= 1'b0;
    rd(4'h0);
    `CHK("stop2 state", 8'h00, d)
    wr(4'h4, 8'h00);
    cyc(1);
    `CHK("gate", 1'b0, module_clock_en)
    wr(4'h0, 8'h80);
    rd(4'h0);
    `CHK("gated ctrl", 8'h00, d)
  endtask : t_power
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_pin();
    t_route();
    t_power();
    end_sim();
  end
  initial begin
    #50us;
    n_errors++;
    end_sim();
  end
endmodule : comparator_event_control_test
bind cec_top cec_top_properties chk_u (.aclk, .aresetn, .s_axi_bvalid,
  .cmp_raw, .wait_mode, .stop3_mode, .stop2_mode, .analog_enable,
  .module_clock_en, .comparator_output_pin_o, .comparator_output_pin_oe,
  .debug_pin_function, .timer_ch0_pin_i, .timer_ch0_oe_i, .timer_ch0_pin_oe,
  .timer_capture_in, .irq, .wakeup);
